// File: rtl/fsir_map.vh
// Register offsets, field positions, reset values and sequencer codes of the fail-safe init bank
//
// Behaviour
// [RL1] Bit 8 set: run the analog self-test on the I/O supply monitor after init.
// [RL2] Bit 9 set: run the analog self-test on the core voltage monitor after init.
// [RL3] Bit 10 set: run the analog self-test on the high-voltage regulator monitor.
// [RL4] Bit 11 set: run the analog self-test on external monitor one after init.
// [RL5] Bit 12 set: run the analog self-test on external monitor two after init.
// [RL6] Bit 13 set: run the analog self-test on external monitor three after init.
// [RL7] Bit 14 set: run the analog self-test on external monitor four after init.
// [RL8] Watchdog refresh counter readable as three-bit field, values 0 to 7.
// [RL9] Watchdog error counter readable as four-bit field, never above 8.
// [RL10] All fields return to defaults only on power-on reset, kept across others.
`ifndef FSIR_MAP_VH
`define FSIR_MAP_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define FSIR_ADDR_W          2
`define FSIR_DATA_W          16
`define FSIR_OFF_SELFTEST    2'h0
`define FSIR_OFF_WDCFG       2'h1
`define FSIR_OFF_SAFEIN      2'h2

// ----------------------------------------------------------------------
// Self-test enable register: bit 8 of the device word is data bit 0
// ----------------------------------------------------------------------
`define FSIR_ST_EN_LSB       0
`define FSIR_ST_EN_MSB       6
`define FSIR_ST_NUM          7
`define FSIR_ST_RST          7'h00

// ----------------------------------------------------------------------
// Watchdog configuration and counters
// ----------------------------------------------------------------------
`define FSIR_WD_ERRLIM_LSB   14
`define FSIR_WD_RFRLIM_LSB   11
`define FSIR_WD_IMPACT_LSB   8
`define FSIR_WD_RFRCNT_LSB   4
`define FSIR_WD_ERRCNT_LSB   0
`define FSIR_WD_ERRLIM_RST   2'h1
`define FSIR_WD_RFRLIM_RST   2'h0
`define FSIR_WD_IMPACT_RST   2'h2
`define FSIR_WD_RFRCNT_RST   3'h0
`define FSIR_WD_ERRCNT_RST   4'h0
`define FSIR_WD_ERRCNT_MAX   4'h8

// ----------------------------------------------------------------------
// Safety input configuration
// ----------------------------------------------------------------------
`define FSIR_SI_CFG_LSB      14
`define FSIR_SI_POL12_BIT    12
`define FSIR_SI_POL1_BIT     11
`define FSIR_SI_POL2_BIT     10
`define FSIR_SI_IMP12_BIT    8
`define FSIR_SI_IMP1_BIT     7
`define FSIR_SI_IMP2_BIT     6
`define FSIR_SI_TWIN_LSB     0
`define FSIR_SI_CFG_RST      2'h1
`define FSIR_SI_POL_RST      1'h0
`define FSIR_SI_IMP_RST      1'h1
`define FSIR_SI_TWIN_RST     4'hA

// ----------------------------------------------------------------------
// Self-test sequencer states
// ----------------------------------------------------------------------
`define FSIR_SQ_IDLE         2'h0
`define FSIR_SQ_SCAN         2'h1
`define FSIR_SQ_WAIT         2'h2
`define FSIR_SQ_END          2'h3

`endif

// File: rtl/fsir_selftest_seq.v
// Sequencer that walks the enabled monitors through the second analog self-test
`timescale 1ns/100ps
`include "fsir_map.vh"

module fsir_selftest_seq
(
	input  wire       clk,
	input  wire       arst_n,
	input  wire       initDone,
	input  wire [6:0] stEnable,
	input  wire       stDone,
	output reg        stStart,
	output reg  [2:0] stMonitor,
	output reg        stBusy,
	output reg        stFinished
);

	reg [1:0] state_q;
	reg [6:0] pending_q;
	reg       initDonePrev_q;

	// ----------------------------------------------------------------------
	// Walk monitors lowest index first
	// ----------------------------------------------------------------------
	// Enables are sampled once at the end of init; later writes do not
	// alter a run already under way.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q        <= `FSIR_SQ_IDLE;
			pending_q      <= 7'h00;
			initDonePrev_q <= 1'b0;
			stStart        <= 1'b0;
			stMonitor      <= 3'h0;
			stBusy         <= 1'b0;
			stFinished     <= 1'b0;
		end
		else
		begin
			initDonePrev_q <= initDone;
			stStart        <= 1'b0;
			case (state_q)
			`FSIR_SQ_IDLE:
			begin
				if (initDone && !initDonePrev_q)
				begin
					pending_q <= stEnable; // RL1 RL2 RL3 RL4 RL5 RL6 RL7
					stBusy    <= 1'b1;
					stMonitor <= 3'h0;
					state_q   <= `FSIR_SQ_SCAN;
				end
			end
			`FSIR_SQ_SCAN:
			begin
				if (stMonitor == 3'h7)
				begin
					stBusy     <= 1'b0;
					stFinished <= 1'b1;
					state_q    <= `FSIR_SQ_END;
				end
				else if (pending_q[stMonitor])
				begin
					stStart <= 1'b1;
					state_q <= `FSIR_SQ_WAIT;
				end
				else
				begin
					stMonitor <= stMonitor + 3'h1; // RL1 RL2 RL3 RL4 RL5 RL6 RL7
				end
			end
			`FSIR_SQ_WAIT:
			begin
				if (stDone)
				begin
					pending_q[stMonitor] <= 1'b0;
					stMonitor            <= stMonitor + 3'h1;
					state_q              <= `FSIR_SQ_SCAN;
				end
			end
			default:
			begin
				state_q <= `FSIR_SQ_END;
			end
			endcase
		end
	end

endmodule

// File: rtl/fsir_regs.v
// Fail-safe init register bank: self-test enables, watchdog config, safety inputs
`timescale 1ns/100ps
`include "fsir_map.vh"

module fsir_regs
(
	input  wire        clk,
	input  wire        arst_n,
	input  wire [1:0]  regAddr,
	input  wire [15:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [15:0] regRdData,
	input  wire        initDone,
	input  wire        stDone,
	output wire        stStart,
	output wire [2:0]  stMonitor,
	output wire        stBusy,
	output wire        stFinished,
	input  wire        wdCntLoad,
	input  wire [2:0]  wdRfrCntIn,
	input  wire [3:0]  wdErrCntIn,
	output reg  [2:0]  watchdogRefreshCount,
	output reg  [3:0]  watchdogErrorCount,
	output reg  [1:0]  wdErrLimit,
	output reg  [1:0]  wdRfrLimit,
	output reg  [1:0]  wdFsImpact,
	output reg  [1:0]  fccuCfg,
	output reg         fccu12FltPol,
	output reg         fccu1FltPol,
	output reg         fccu2FltPol,
	output reg         fccu12FsImpact,
	output reg         fccu1FsImpact,
	output reg         fccu2FsImpact,
	output reg  [3:0]  timingWindowStby
);

	// ----------------------------------------------------------------------
	// Self-test enable flops
	// ----------------------------------------------------------------------
	// Bit order: I/O supply, core, high-voltage regulator, external 1..4
	reg  [6:0]  stEnable_q;
	wire        wrSelftest;
	wire        wrWdCfg;
	wire        wrSafeIn;
	reg  [15:0] rdMux_d;

	assign wrSelftest = regWr && (regAddr == `FSIR_OFF_SELFTEST);
	assign wrWdCfg    = regWr && (regAddr == `FSIR_OFF_WDCFG);
	assign wrSafeIn   = regWr && (regAddr == `FSIR_OFF_SAFEIN);

	// One flop per enable; arst_n is the power-on reset and no other reset
	// clears these, so a functional reset elsewhere leaves them intact.
	localparam [6:0] ST_RESET = `FSIR_ST_RST;

	genvar gi;
	generate
		for (gi = 0; gi < `FSIR_ST_NUM; gi = gi + 1)
		begin : gEnable
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					stEnable_q[gi] <= ST_RESET[gi]; // RL10
				end
				else if (wrSelftest)
				begin
					stEnable_q[gi] <= regWrData[`FSIR_ST_EN_LSB + gi]; // RL1 RL2 RL3 RL4 RL5 RL6 RL7
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Watchdog configuration fields
	// ----------------------------------------------------------------------
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wdErrLimit <= `FSIR_WD_ERRLIM_RST; // RL10
			wdRfrLimit <= `FSIR_WD_RFRLIM_RST;
			wdFsImpact <= `FSIR_WD_IMPACT_RST;
		end
		else if (wrWdCfg)
		begin
			wdErrLimit <= regWrData[`FSIR_WD_ERRLIM_LSB +: 2];
			wdRfrLimit <= regWrData[`FSIR_WD_RFRLIM_LSB +: 2];
			wdFsImpact <= regWrData[`FSIR_WD_IMPACT_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------------
	// Watchdog counters
	// ----------------------------------------------------------------------
	// Counters are read-only to software; the watchdog loads them. An
	// error value above the ceiling is clipped so the field never shows
	// more than the watchdog can legally reach.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			watchdogRefreshCount <= `FSIR_WD_RFRCNT_RST; // RL10
			watchdogErrorCount   <= `FSIR_WD_ERRCNT_RST; // RL10
		end
		else if (wdCntLoad)
		begin
			watchdogRefreshCount <= wdRfrCntIn; // RL8
			if (wdErrCntIn > `FSIR_WD_ERRCNT_MAX)
			begin
				watchdogErrorCount <= `FSIR_WD_ERRCNT_MAX; // RL9
			end
			else
			begin
				watchdogErrorCount <= wdErrCntIn; // RL9
			end
		end
	end

	// ----------------------------------------------------------------------
	// Safety input configuration fields
	// ----------------------------------------------------------------------
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fccuCfg          <= `FSIR_SI_CFG_RST; // RL10
			fccu12FltPol     <= `FSIR_SI_POL_RST;
			fccu1FltPol      <= `FSIR_SI_POL_RST;
			fccu2FltPol      <= `FSIR_SI_POL_RST;
			fccu12FsImpact   <= `FSIR_SI_IMP_RST;
			fccu1FsImpact    <= `FSIR_SI_IMP_RST;
			fccu2FsImpact    <= `FSIR_SI_IMP_RST;
			timingWindowStby <= `FSIR_SI_TWIN_RST;
		end
		else if (wrSafeIn)
		begin
			fccuCfg          <= regWrData[`FSIR_SI_CFG_LSB +: 2];
			fccu12FltPol     <= regWrData[`FSIR_SI_POL12_BIT];
			fccu1FltPol      <= regWrData[`FSIR_SI_POL1_BIT];
			fccu2FltPol      <= regWrData[`FSIR_SI_POL2_BIT];
			fccu12FsImpact   <= regWrData[`FSIR_SI_IMP12_BIT];
			fccu1FsImpact    <= regWrData[`FSIR_SI_IMP1_BIT];
			fccu2FsImpact    <= regWrData[`FSIR_SI_IMP2_BIT];
			timingWindowStby <= regWrData[`FSIR_SI_TWIN_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------
	// Reserved bits and the unmapped index read as zero.
	always @*
	begin
		rdMux_d = 16'h0000;
		case (regAddr)
		`FSIR_OFF_SELFTEST:
		begin
			rdMux_d[`FSIR_ST_EN_MSB:`FSIR_ST_EN_LSB] = stEnable_q;
		end
		`FSIR_OFF_WDCFG:
		begin
			rdMux_d[`FSIR_WD_ERRLIM_LSB +: 2] = wdErrLimit;
			rdMux_d[`FSIR_WD_RFRLIM_LSB +: 2] = wdRfrLimit;
			rdMux_d[`FSIR_WD_IMPACT_LSB +: 2] = wdFsImpact;
			rdMux_d[`FSIR_WD_RFRCNT_LSB +: 3] = watchdogRefreshCount; // RL8
			rdMux_d[`FSIR_WD_ERRCNT_LSB +: 4] = watchdogErrorCount; // RL9
		end
		`FSIR_OFF_SAFEIN:
		begin
			rdMux_d[`FSIR_SI_CFG_LSB +: 2]  = fccuCfg;
			rdMux_d[`FSIR_SI_POL12_BIT]     = fccu12FltPol;
			rdMux_d[`FSIR_SI_POL1_BIT]      = fccu1FltPol;
			rdMux_d[`FSIR_SI_POL2_BIT]      = fccu2FltPol;
			rdMux_d[`FSIR_SI_IMP12_BIT]     = fccu12FsImpact;
			rdMux_d[`FSIR_SI_IMP1_BIT]      = fccu1FsImpact;
			rdMux_d[`FSIR_SI_IMP2_BIT]      = fccu2FsImpact;
			rdMux_d[`FSIR_SI_TWIN_LSB +: 4] = timingWindowStby;
		end
		default:
		begin
			rdMux_d = 16'h0000;
		end
		endcase
	end

	// Data stands only in the cycle after the read strobe, zero otherwise
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			regRdData <= 16'h0000;
		end
		else if (regRd)
		begin
			regRdData <= rdMux_d;
		end
		else
		begin
			regRdData <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------------
	// Self-test sequencer
	// ----------------------------------------------------------------------
	fsir_selftest_seq uSeq
	(
		.clk        (clk),
		.arst_n     (arst_n),
		.initDone   (initDone),
		.stEnable   (stEnable_q),
		.stDone     (stDone),
		.stStart    (stStart),
		.stMonitor  (stMonitor),
		.stBusy     (stBusy),
		.stFinished (stFinished)
	);

endmodule

// File: verification/fsir_regs_properties.sv
// Port-level assertions for the fail-safe init register bank
`timescale 1ns/100ps
module fsir_regs_checker
(
	input logic        clk,
	input logic        arst_n,
	input logic [1:0]  regAddr,
	input logic [15:0] regWrData,
	input logic        regWr,
	input logic        initDone,
	input logic        stStart,
	input logic [2:0]  stMonitor,
	input logic        stBusy,
	input logic        stFinished,
	input logic        wdCntLoad,
	input logic [2:0]  wdRfrCntIn,
	input logic [3:0]  wdErrCntIn,
	input logic [2:0]  watchdogRefreshCount,
	input logic [3:0]  watchdogErrorCount
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Bit 7 stays low so the index past the last monitor never looks enabled
	logic [7:0] enShadow_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			enShadow_q <= 8'h00;
		else if (regWr && regAddr == 2'h0 && !stBusy)
			enShadow_q <= {1'b0, regWrData[6:0]};
	end

	sequence s_scan;
		($rose(stBusy) || $changed(stMonitor)) && stBusy && stMonitor != 3'h7;
	endsequence
	property p_st_launch;
		s_scan ##0 enShadow_q[stMonitor] |=> stStart && $stable(stMonitor);
	endproperty
	property p_st_skip;
		s_scan ##0 !enShadow_q[stMonitor] |=> !stStart && stMonitor == $past(stMonitor) + 3'h1;
	endproperty
	property p_st_start;
		stStart |-> enShadow_q[stMonitor];
	endproperty
	property p_st_begin;
		$rose(initDone) && !stBusy && !stFinished |=> stBusy && stMonitor == 3'h0;
	endproperty
	property p_st_end;
		$fell(stBusy) |-> stFinished ##1 stFinished;
	endproperty
	property p_rfr_load;
		wdCntLoad |=> watchdogRefreshCount == $past(wdRfrCntIn);
	endproperty
	property p_err_load;
		wdCntLoad |=> watchdogErrorCount == (($past(wdErrCntIn) > 4'h8) ? 4'h8 : $past(wdErrCntIn));
	endproperty
	property p_cnt_hold;
		!wdCntLoad |=> $stable(watchdogRefreshCount) && $stable(watchdogErrorCount);
	endproperty

	a_st_launch: assert property (p_st_launch)
		else $error("enabled monitor not started");
	a_st_skip: assert property (p_st_skip)
		else $error("disabled monitor not skipped");
	a_st_start: assert property (p_st_start)
		else $error("start on disabled monitor");
	a_st_begin: assert property (p_st_begin)
		else $error("run did not begin after init");
	a_st_end: assert property (p_st_end)
		else $error("finished flag missing");
	a_rfr_load: assert property (p_rfr_load)
		else $error("refresh count wrong");
	a_err_load: assert property (p_err_load)
		else $error("error count wrong");
	a_cnt_hold: assert property (p_cnt_hold)
		else $error("counter moved without load");
endmodule

bind fsir_regs fsir_regs_checker fsir_regs_checker_inst (.clk, .arst_n, .regAddr, .regWrData,
	.regWr, .initDone, .stStart, .stMonitor, .stBusy, .stFinished, .wdCntLoad, .wdRfrCntIn,
	.wdErrCntIn, .watchdogRefreshCount, .watchdogErrorCount);

// File: verification/fsir_regs_tb.sv
// Self-checking bench for the fail-safe init register bank
`timescale 1ns/100ps
module fsir_regs_tb;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [1:0]  regAddr = 2'h0;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        initDone = 1'b0;
	logic        stDone = 1'b0;
	logic        wdCntLoad = 1'b0;
	logic [2:0]  wdRfrCntIn = 3'h0;
	logic [3:0]  wdErrCntIn = 4'h0;
	wire  [15:0] regRdData;
	wire         stStart;
	wire  [2:0]  stMonitor;
	wire         stBusy;
	wire         stFinished;
	// Output fields gathered at their register bit positions
	wire  [15:0] wdOut;
	wire  [15:0] siOut;
	integer      miscompares = 0;
	integer      checkCount = 0;
	integer      v;
	// Row: index, write data, expected read back
	logic [33:0] rows [7] = '{{2'h0, 16'hFFFF, 16'h007F}, {2'h1, 16'hFFFF, 16'hDB00},
		{2'h2, 16'hFFFF, 16'hDDCF}, {2'h3, 16'hFFFF, 16'h0000}, {2'h0, 16'h0000, 16'h0000},
		{2'h1, 16'h0000, 16'h0000}, {2'h2, 16'h0000, 16'h0000}};

	always #4 clk = ~clk;

	assign wdOut[13]  = 1'b0;
	assign wdOut[10]  = 1'b0;
	assign wdOut[7]   = 1'b0;
	assign siOut[13]  = 1'b0;
	assign siOut[9]   = 1'b0;
	assign siOut[5:4] = 2'h0;

	fsir_regs fsir_regs_inst (.clk, .arst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.initDone, .stDone, .stStart, .stMonitor, .stBusy, .stFinished, .wdCntLoad, .wdRfrCntIn,
		.wdErrCntIn, .watchdogRefreshCount(wdOut[6:4]), .watchdogErrorCount(wdOut[3:0]),
		.wdErrLimit(wdOut[15:14]), .wdRfrLimit(wdOut[12:11]), .wdFsImpact(wdOut[9:8]),
		.fccuCfg(siOut[15:14]), .fccu12FltPol(siOut[12]), .fccu1FltPol(siOut[11]),
		.fccu2FltPol(siOut[10]), .fccu12FsImpact(siOut[8]), .fccu1FsImpact(siOut[7]),
		.fccu2FsImpact(siOut[6]), .timingWindowStby(siOut[3:0]));

	// ----------------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------------
	task chk(input [15:0] seen, input [15:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input [1:0] a, input [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task rd(input [1:0] a, input [15:0] exp);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
		@(posedge clk);
	endtask

	task por;
		initDone <= 1'b0;
		arst_n <= 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask

	// Answers every start with a one-cycle done, lowest enabled monitor first
	task run_st(input [6:0] en);
		integer k, n, w;
		k = 0;
		w = 0;
		wr(2'h0, {9'h000, en});
		initDone <= 1'b1;
		for (n = 0; n < 300 && stFinished !== 1'b1; n++)
		begin
			@(posedge clk);
			stDone <= (w == 1);
			if (w > 0)
				w--;
			// Outputs are looked at once settled, not in the launching step
			#1;
			if (stStart === 1'b1)
			begin
				while (k < 7 && !en[k])
					k++;
				chk({13'h0000, stMonitor}, k[15:0]);
				k++;
				w = 3;
			end
		end
		chk({15'h0000, stFinished}, 16'h0001);
		chk({9'h000, en} >> k, 16'h0000);
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial
	begin
		por;
		rd(2'h0, 16'h0000);
		rd(2'h1, 16'h4200);
		rd(2'h2, 16'h41CA);
		rd(2'h3, 16'h0000);
		chk(wdOut, 16'h4200);
		chk(siOut, 16'h41CA);
		foreach (rows[i])
		begin
			wr(rows[i][33:32], rows[i][31:16]);
			rd(rows[i][33:32], rows[i][15:0]);
			if (rows[i][33:32] == 2'h1)
				chk(wdOut, rows[i][15:0]);
			else if (rows[i][33:32] == 2'h2)
				chk(siOut, rows[i][15:0]);
		end
		for (v = 0; v < 16; v++)
		begin
			wdRfrCntIn <= v[2:0];
			wdErrCntIn <= v[3:0];
			wdCntLoad <= 1'b1;
			@(posedge clk);
			wdCntLoad <= 1'b0;
			rd(2'h1, {9'h000, v[2:0], (v > 8) ? 4'h8 : v[3:0]});
			chk(wdOut, {9'h000, v[2:0], (v > 8) ? 4'h8 : v[3:0]});
		end
		run_st(7'h45);
		por;
		rd(2'h0, 16'h0000);
		rd(2'h1, 16'h4200);
		chk(wdOut, 16'h4200);
		chk(siOut, 16'h41CA);
		run_st(7'h3A);
		complete_run;
	end

	// Whole run is well under two thousand cycles
	initial
	begin
		#100000;
		miscompares++;
		complete_run;
	end
endmodule
